// ==== pkg/ast_defs.svh ====
// Register offsets, field positions, reset values and counts for the timer
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define AST_OFS_COUNT   8'h00
`define AST_OFS_COMPARE 8'h04
`define AST_OFS_CONTROL 8'h08
`define AST_OFS_STATUS  8'h0C
`define AST_OFS_FLAGS   8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AST_BIT_ASYNC_SEL   3
`define AST_BIT_COUNT_BUSY  2
`define AST_BIT_CMP_BUSY    1
`define AST_BIT_CTL_BUSY    0
`define AST_BIT_CMP_FLAG    1
`define AST_BIT_OVF_FLAG    0
`define AST_CTL_COM_HI      5
`define AST_CTL_COM_LO      4
`define AST_CTL_CS_HI       2

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define AST_RST_COMPARE     8'h00
`define AST_RST_CONTROL     8'h00
`define AST_RST_COUNT       8'h00
`define AST_COUNT_MAX       8'hFF
`define AST_XFER_EDGES      2'h2
`define AST_FLAG_SYNC_CYC   3

`endif

// ==== pkg/ast_pkg.sv ====
// Types shared by the asynchronous timer register block
`default_nettype none
package ast_pkg;

  // Holding-register index
  typedef enum logic [1:0] {
    AST_H_COUNT = 2'b00,
    AST_H_CMP   = 2'b01,
    AST_H_CTL   = 2'b10
  } ast_hold_t;

  // Compare output action, non-PWM
  typedef enum logic [1:0] {
    AST_COM_OFF    = 2'b00,
    AST_COM_TOGGLE = 2'b01,
    AST_COM_CLEAR  = 2'b10,
    AST_COM_SET    = 2'b11
  } ast_com_t;

  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  cmp;
    logic [7:0]  ctl;
    logic [2:0][7:0] hold;
    logic [2:0]  pend;
    logic [2:0][1:0] edges;
    logic        async_sel;
    logic [7:0]  count_view;
    logic        blk;
    logic        cmp_flag;
    logic        ovf_flag;
    logic [2:0]  cmp_pipe;
    logic [2:0]  ovf_pipe;
    logic        osc_d;
    logic        oc_pin;
    logic        ack;
    logic [7:0]  rdata;
  } ast_state_t;

endpackage
`default_nettype wire

// ==== design/ast_timer_sync.sv ====
// Asynchronous 8-bit timer registers, holding registers and busy flags
//
// Overview of operation
// [R1] Count reads and writes directly; a write blocks the next tick's match.
// [R2] Compare value checked against count each tick; match sets flag, pin.
// [R3] Status bit 3 picks the tick source: io clock or crystal input.
// [R4] Changing the clock source may corrupt all three; software rewrites.
// [R5] Async count write sets count busy bit 2 until loaded.
// [R6] Async compare write sets compare busy bit 1 until loaded.
// [R7] Async control write sets control busy bit 0 until loaded.
// [R8] Software must not write a register whose busy flag is set.
// [R9] Count read returns the synchronised copy; compare and control read holding copies.
// [R10] Software follows the documented sequence when switching clock source.
// [R11] Processor clock must exceed four times the crystal frequency.
// [R12] Each register has its own holding copy, loaded after two crystal edges.
// [R13] Compare matching is off while a count or compare write is pending.
// [R14] Software waits for pending writes before entering timer-wake sleep.
// [R15] Interrupt logic needs one crystal cycle to reset after wake-up.
// [R16] Oscillator runs in async mode except in power-down and standby.
// [R17] Software waits one second after power-up before using async timer.
// [R18] Wake-up starts on next timer tick, so count advances at least one.
// [R19] Count reads go through a copy refreshed on each rising crystal edge.
// [R20] Software writes compare or control and waits busy before reading count.
// [R21] Async flag synchronisation takes three cycles plus one timer tick.
// [R22] Compare output pin changes on the timer tick, not resynchronised.
// [R23] Flags clear on vector execution or on a written one.
// [R24] Busy bits and unused status bits are read-only.
//
// Register access over Avalon-MM and the address map were decided locally.
`default_nettype none
`include "ast_defs.svh"

module ast_timer_sync (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic [1:0]       response,
  output logic             waitrequest,
  // Crystal and sleep
  input  wire logic        crystal_osc_input,
  input  wire logic        sleep_osc_off,
  output logic             osc_enable,
  // Interrupt vector acknowledges
  input  wire logic        cmp_vector_ack,
  input  wire logic        ovf_vector_ack,
  // Timer outputs
  output logic             compare_match_flag,
  output logic             overflow_flag,
  output logic             compare_output_pin,
  output logic [7:0]       timer_control
);

  ast_pkg::ast_state_t s_r;
  ast_pkg::ast_state_t s_nxt;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic       req;
  logic       take;
  logic       wr;
  logic       mapped;
  logic       xedge;
  logic       tick;
  logic       run;
  logic       match;
  logic       ovf;
  logic [7:0] wbyte;

  assign req    = read | write;
  // Two-cycle access: request sampled, answer on the next edge
  assign take   = req & s_r.ack;
  assign wr     = write & ~s_r.ack & byteenable[0];
  assign wbyte  = writedata[7:0];
  assign mapped = (address == `AST_OFS_COUNT) |
                  (address == `AST_OFS_COMPARE) |
                  (address == `AST_OFS_CONTROL) |
                  (address == `AST_OFS_STATUS) |
                  (address == `AST_OFS_FLAGS);

  // --------------------------------------------------------------------
  // Tick source
  // --------------------------------------------------------------------
  // Crystal taken as synchronous input; processor clock must be >4x it
  assign xedge = crystal_osc_input & ~s_r.osc_d; // R11
  assign tick  = s_r.async_sel ? xedge : 1'b1; // R3
  assign run   = s_r.ctl[`AST_CTL_CS_HI:0] != 3'h0;
  // No match while a count or compare transfer is in flight
  assign match = tick & run & (s_r.count == s_r.cmp) & ~s_r.blk &
                 ~s_r.pend[ast_pkg::AST_H_COUNT] &
                 ~s_r.pend[ast_pkg::AST_H_CMP]; // R13
  assign ovf   = tick & run & (s_r.count == `AST_COUNT_MAX);

  always_comb begin
    s_nxt        = s_r;
    s_nxt.osc_d  = crystal_osc_input;
    s_nxt.ack    = req & ~s_r.ack;

    // ------------------------------------------------------------------
    // Counting and compare
    // ------------------------------------------------------------------
    if (tick & run) begin
      s_nxt.count = s_r.count + 8'h01; // R18
      s_nxt.blk   = 1'b0;
    end
    if (match) begin // R2
      unique case (ast_pkg::ast_com_t'(
          s_r.ctl[`AST_CTL_COM_HI:`AST_CTL_COM_LO]))
        ast_pkg::AST_COM_OFF:    s_nxt.oc_pin = s_r.oc_pin;
        ast_pkg::AST_COM_TOGGLE: s_nxt.oc_pin = ~s_r.oc_pin; // R22
        ast_pkg::AST_COM_CLEAR:  s_nxt.oc_pin = 1'b0;
        ast_pkg::AST_COM_SET:    s_nxt.oc_pin = 1'b1;
      endcase
    end

    // Count view refreshed every cycle in sync mode, on each rising crystal edge in async mode; sleep_osc_off does not gate it
    if (!s_r.async_sel || xedge) begin
      s_nxt.count_view = s_nxt.count; // R19
    end

    // ------------------------------------------------------------------
    // Holding-register transfer
    // ------------------------------------------------------------------
    for (int i = 0; i < 3; i++) begin // R12 R15
      if (s_r.pend[i] && xedge) begin
        s_nxt.edges[i] = s_r.edges[i] + 2'h1;
        if (s_r.edges[i] + 2'h1 == `AST_XFER_EDGES) begin
          s_nxt.pend[i]  = 1'b0; // R5 R6 R7
          s_nxt.edges[i] = 2'h0;
          unique case (ast_pkg::ast_hold_t'(2'(i)))
            ast_pkg::AST_H_COUNT: begin
              s_nxt.count = s_r.hold[i];
              s_nxt.blk   = 1'b1; // R1
            end
            ast_pkg::AST_H_CMP: s_nxt.cmp = s_r.hold[i];
            ast_pkg::AST_H_CTL: s_nxt.ctl = s_r.hold[i];
            default: s_nxt.ctl = s_r.ctl;
          endcase
        end
      end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    if (wr) begin
      unique case (address)
        `AST_OFS_COUNT: begin
          s_nxt.hold[ast_pkg::AST_H_COUNT] = wbyte;
          if (s_r.async_sel) begin
            s_nxt.pend[ast_pkg::AST_H_COUNT]  = 1'b1; // R5
            s_nxt.edges[ast_pkg::AST_H_COUNT] = 2'h0;
          end else begin
            s_nxt.count = wbyte; // R1
            s_nxt.blk   = 1'b1;
          end
        end
        `AST_OFS_COMPARE: begin
          s_nxt.hold[ast_pkg::AST_H_CMP] = wbyte;
          if (s_r.async_sel) begin
            s_nxt.pend[ast_pkg::AST_H_CMP]  = 1'b1; // R6
            s_nxt.edges[ast_pkg::AST_H_CMP] = 2'h0;
          end else begin
            s_nxt.cmp = wbyte;
          end
        end
        `AST_OFS_CONTROL: begin
          s_nxt.hold[ast_pkg::AST_H_CTL] = wbyte;
          if (s_r.async_sel) begin
            s_nxt.pend[ast_pkg::AST_H_CTL]  = 1'b1; // R7
            s_nxt.edges[ast_pkg::AST_H_CTL] = 2'h0;
          end else begin
            s_nxt.ctl = wbyte;
          end
        end
        `AST_OFS_STATUS: begin
          // Only the select bit is writable
          s_nxt.async_sel = wbyte[`AST_BIT_ASYNC_SEL]; // R24
          if (wbyte[`AST_BIT_ASYNC_SEL] != s_r.async_sel) begin
            // Transfers in flight are meaningless after a source change
            s_nxt.pend = 3'h0; // R4
            s_nxt.edges = '0;
          end
        end
        `AST_OFS_FLAGS: begin
          if (wbyte[`AST_BIT_CMP_FLAG]) s_nxt.cmp_flag = 1'b0; // R23
          if (wbyte[`AST_BIT_OVF_FLAG]) s_nxt.ovf_flag = 1'b0; // R23
        end
        default: s_nxt.ack = s_nxt.ack;
      endcase
    end

    // ------------------------------------------------------------------
    // Flags; hardware set wins over any clear in the same cycle
    // ------------------------------------------------------------------
    if (cmp_vector_ack) s_nxt.cmp_flag = 1'b0; // R23
    if (ovf_vector_ack) s_nxt.ovf_flag = 1'b0; // R23
    s_nxt.cmp_pipe = {s_r.cmp_pipe[1:0], match};
    s_nxt.ovf_pipe = {s_r.ovf_pipe[1:0], ovf};
    if (s_r.async_sel) begin
      // Crossing into processor domain costs three cycles
      if (s_r.cmp_pipe[`AST_FLAG_SYNC_CYC-1]) s_nxt.cmp_flag = 1'b1; // R21
      if (s_r.ovf_pipe[`AST_FLAG_SYNC_CYC-1]) s_nxt.ovf_flag = 1'b1; // R21
    end else begin
      if (match) s_nxt.cmp_flag = 1'b1; // R2
      if (ovf)   s_nxt.ovf_flag = 1'b1;
    end

    // ------------------------------------------------------------------
    // Read data, captured in the request cycle
    // ------------------------------------------------------------------
    s_nxt.rdata = 8'h00;
    if (read & ~s_r.ack) begin
      unique case (address)
        `AST_OFS_COUNT:   s_nxt.rdata = s_r.count_view; // R9
        `AST_OFS_COMPARE: s_nxt.rdata = s_r.async_sel ?
                          s_r.hold[ast_pkg::AST_H_CMP] : s_r.cmp; // R9
        `AST_OFS_CONTROL: s_nxt.rdata = s_r.async_sel ?
                          s_r.hold[ast_pkg::AST_H_CTL] : s_r.ctl; // R9
        `AST_OFS_STATUS:  s_nxt.rdata = {4'h0, s_r.async_sel,
                          s_r.pend[ast_pkg::AST_H_COUNT],
                          s_r.pend[ast_pkg::AST_H_CMP],
                          s_r.pend[ast_pkg::AST_H_CTL]}; // R24
        `AST_OFS_FLAGS:   s_nxt.rdata = {6'h00, s_r.cmp_flag,
                          s_r.ovf_flag};
        default:          s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r       <= '0;
      s_r.cmp   <= `AST_RST_COMPARE;
      s_r.ctl   <= `AST_RST_CONTROL;
      s_r.count <= `AST_RST_COUNT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  logic err_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_r <= 1'b0;
    end else begin
      err_r <= req & ~s_r.ack & ~mapped;
    end
  end

  assign waitrequest        = req & ~s_r.ack;
  assign readdata           = {24'h00_0000, s_r.rdata};
  // Unmapped address answers with a slave error
  assign response           = (take & err_r) ? 2'b10 : 2'b00;
  // Oscillator runs only in async mode, and stops there in power-down and standby
  assign osc_enable         = s_r.async_sel & ~sleep_osc_off; // R16
  assign compare_match_flag = s_r.cmp_flag;
  assign overflow_flag      = s_r.ovf_flag;
  assign compare_output_pin = s_r.oc_pin; // R22
  assign timer_control      = s_r.ctl;

endmodule
`default_nettype wire

// ==== tb/ast_timer_checker.sv ====
// Port-level assertions for the asynchronous timer register block
`default_nettype none
`include "ast_defs.svh"
module ast_timer_checker (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic [1:0]  response,
  input wire logic        waitrequest,
  // Timer side
  input wire logic        sleep_osc_off,
  input wire logic        osc_enable,
  input wire logic        cmp_vector_ack,
  input wire logic        ovf_vector_ack,
  input wire logic        compare_match_flag,
  input wire logic        overflow_flag,
  input wire logic        compare_output_pin,
  input wire logic [7:0]  timer_control
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic req;
  logic mapped;
  logic fclr;
  assign req = read || write;
  assign mapped = address <= `AST_OFS_FLAGS && address[1:0] == 2'b00;
  assign fclr = write && byteenable[0] && address == `AST_OFS_FLAGS;
  // ------------------------------------------------------------
  // Bus and flag relations
  // ------------------------------------------------------------
  wait_one_a: assert property (req && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  bus_idle_a: assert property (!req |-> !waitrequest)
    else $error("waitrequest high while idle");
  resp_err_a: assert property (
    req && !waitrequest && !mapped |-> response == 2'b10)
    else $error("unmapped access not refused");
  resp_ok_a: assert property (
    req && !waitrequest && mapped |-> response == 2'b00)
    else $error("mapped access refused");
  rdata_upper_a: assert property (
    read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  osc_stop_a: assert property (sleep_osc_off |-> !osc_enable)
    else $error("oscillator enabled in deep sleep");
  // Clear must trace to an ack or a written one
  cmp_clear_a: assert property (
    $fell(compare_match_flag) |->
      $past(cmp_vector_ack || fclr && writedata[1]))
    else $error("compare flag cleared without cause");
  ovf_clear_a: assert property (
    $fell(overflow_flag) |->
      $past(ovf_vector_ack || fclr && writedata[0]))
    else $error("overflow flag cleared without cause");
  pin_source_a: assert property (
    $changed(compare_output_pin) |-> $past(timer_control[5:4]) != 2'b00)
    else $error("pin moved with output action off");
  cover property (fclr && writedata[1] && compare_match_flag);
  cover property ($fell(compare_match_flag) && $past(cmp_vector_ack));
  cover property ($rose(compare_output_pin));
  cover property (req && !waitrequest && !mapped);
endmodule
bind ast_timer_sync ast_timer_checker u_ast_timer_checker (.clk, .nrst,
  .address, .read, .write, .writedata, .byteenable, .readdata, .response,
  .waitrequest, .sleep_osc_off, .osc_enable, .cmp_vector_ack,
  .ovf_vector_ack, .compare_match_flag, .overflow_flag,
  .compare_output_pin, .timer_control);
`default_nettype wire

// ==== tb/ast_timer_sync_bench.sv ====
// Self-checking bench for the asynchronous timer register block
`default_nettype none
`include "ast_defs.svh"
module ast_timer_sync_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, read, write, xtal, sleep, cack, oack;
  logic        wreq, osc_en, cflag, oflag, pin;
  logic [7:0]  address, tctl;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  resp, rs;
  logic [3:0]  be;
  int          err_total, samples_checked;
  ast_timer_sync u_ast_timer_sync (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(wdata),
    .byteenable(be), .readdata(rdata), .response(resp),
    .waitrequest(wreq), .crystal_osc_input(xtal), .sleep_osc_off(sleep),
    .osc_enable(osc_en), .cmp_vector_ack(cack), .ovf_vector_ack(oack),
    .compare_match_flag(cflag), .overflow_flag(oflag),
    .compare_output_pin(pin), .timer_control(tctl));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    wdata <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      err_total++;
      $display("Error waitrequest expected 0 seen %b", wreq);
      close_out();
    end
    rd = rdata;
    rs = resp;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e, string what);
    bus(1'b0, a, 8'h00);
    chk(what, {24'h00_0000, e}, rd);
  endtask
  // Crystal runs well below a quarter of the bus clock, already settled
  task automatic tick();
    repeat (4) @(posedge clk);
    xtal <= 1'b1;
    repeat (4) @(posedge clk);
    xtal <= 1'b0;
  endtask
  task automatic wait_flag(logic [7:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, `AST_OFS_FLAGS, 8'h00);
      n++;
    end while ((rd[7:0] & m) !== m && n < 400);
    chk("flag", {24'h00_0000, m}, rd & {24'h00_0000, m});
    if ((rd[7:0] & m) !== m) begin
      close_out();
    end
  endtask
  task automatic t_ack(logic cmp);
    wait_flag(cmp ? 8'h02 : 8'h01);
    @(posedge clk);
    cack <= cmp;
    oack <= !cmp;
    @(posedge clk);
    cack <= 1'b0;
    oack <= 1'b0;
    @(posedge clk);
    chk("acked flag", 32'h0000_0000, {31'h0, cmp ? cflag : oflag});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc(`AST_OFS_STATUS, 8'h00, "status");
    rdc(`AST_OFS_COMPARE, `AST_RST_COMPARE, "compare");
    // Byte lane zero off: the write must be ignored
    be <= 4'h0;
    bus(1'b1, `AST_OFS_COMPARE, 8'h55);
    be <= 4'hF;
    rdc(`AST_OFS_COMPARE, `AST_RST_COMPARE, "lane off write");
    rdc(`AST_OFS_FLAGS, 8'h00, "flags");
    rdc(8'h14, 8'h00, "unmapped data");
    chk("unmapped resp", 32'h0000_0002, {30'h0, rs});
  endtask
  task automatic t_sync();
    bus(1'b1, `AST_OFS_COMPARE, 8'h40);
    bus(1'b1, `AST_OFS_COUNT, 8'h00);
    bus(1'b1, `AST_OFS_CONTROL, 8'h11);
    chk("control", 32'h0000_0011, {24'h00_0000, tctl});
    wait_flag(8'h02);
    chk("pin set", 32'h0000_0001, {31'h0, pin});
    bus(1'b1, `AST_OFS_FLAGS, 8'h02);
    chk("cmp cleared", 32'h0000_0000, {31'h0, cflag});
    // Count written equal to compare: the next tick must not match
    bus(1'b1, `AST_OFS_COUNT, 8'h40);
    repeat (6) @(posedge clk);
    chk("match blocked", 32'h0000_0000, {31'h0, cflag});
    t_ack(1'b0);
    t_ack(1'b1);
    chk("pin toggled", 32'h0000_0000, {31'h0, pin});
    bus(1'b1, `AST_OFS_CONTROL, 8'h00);
  endtask
  task automatic t_async();
    bus(1'b1, `AST_OFS_STATUS, 8'hFF);
    rdc(`AST_OFS_STATUS, 8'h08, "status ro");
    chk("osc on", 32'h0000_0001, {31'h0, osc_en});
    bus(1'b1, `AST_OFS_COMPARE, 8'h33);
    bus(1'b1, `AST_OFS_COUNT, 8'h10);
    rdc(`AST_OFS_STATUS, 8'h0E, "busy set");
    rdc(`AST_OFS_COMPARE, 8'h33, "holding");
    tick();
    rdc(`AST_OFS_STATUS, 8'h0E, "busy one edge");
    tick();
    rdc(`AST_OFS_STATUS, 8'h08, "busy clear");
    bus(1'b1, `AST_OFS_CONTROL, 8'h00);
    rdc(`AST_OFS_STATUS, 8'h09, "ctl busy");
    repeat (2) tick();
    rdc(`AST_OFS_STATUS, 8'h08, "ctl clear");
    rdc(`AST_OFS_COUNT, 8'h10, "count view");
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    chk("osc off", 32'h0000_0000, {31'h0, osc_en});
    sleep <= 1'b0;
  endtask
  // Async compare: a pending write masks the match, flags lag the tick
  task automatic t_amatch();
    bus(1'b1, `AST_OFS_COUNT, 8'h32);
    bus(1'b1, `AST_OFS_CONTROL, 8'h01);
    repeat (3) tick();
    // Count now equals compare; the compare write is still in flight
    bus(1'b1, `AST_OFS_COMPARE, 8'h33);
    repeat (2) tick();
    chk("match masked", 32'h0000_0000, {31'h0, cflag});
    bus(1'b1, `AST_OFS_COUNT, 8'h31);
    repeat (5) tick();
    chk("flag lag", 32'h0000_0000, {31'h0, cflag});
    @(posedge clk);
    chk("flag synced", 32'h0000_0001, {31'h0, cflag});
    chk("pin held", 32'h0000_0000, {31'h0, pin});
    t_ack(1'b1);
    bus(1'b1, `AST_OFS_CONTROL, 8'h00);
  endtask
  initial begin
    {nrst, read, write, xtal, sleep, cack, oack} = 7'h00;
    address = 8'h00;
    be = 4'hF;
    wdata = 32'h0000_0000;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_sync();
    t_async();
    t_amatch();
    close_out();
  end
endmodule
`default_nettype wire
